// *** logic/mps_pin_select.v ***
// Purpose: Select decode and monitor mapping for four multipurpose pins
// Assumes: Analog comparators report above-upper and below-lower levels
// Notes: One clock pclk, APB slave with zero wait states
//
// Operation
// - Pin 1 select bits 3:1; 000/001 first AC sense
// - Pin 2 select bits 7:5; 000/001 second AC sense
// - Pin 3 bits 4:2; power-on request polarity
// - 010: flag and overvoltage above upper
// - 011: undervoltage low side, flag high above
// - 100: overvoltage low side, flag high above
// - 101: undervoltage and flag above upper
// - Flag follows hysteretic comparator, inverted in 111; 110 flag only
// - DC good output uses polarity control bit
//
// Local design decisions: the APB slave port and the address map.
`include "mps_map.vh"
`default_nettype none

module mps_pin_select (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // Comparator levels per pin, asynchronous
  input wire [3:0] cmp_above_upper,
  input wire [3:0] cmp_below_lower,
  // Threshold window per pin: 1 = 1.25/1.35 V, 0 = 1.15/1.25 V
  output reg [3:0] thr_window_high,
  // Digital level of pins 1 to 3, asynchronous
  input wire multipurpose_pin_1,
  input wire multipurpose_pin_2,
  input wire multipurpose_pin_3,
  // Pin 4 drive
  output reg multipurpose_pin_4_out,
  output reg multipurpose_pin_4_oe,
  // Dedicated functions
  output reg ac_sense_input_first,
  output reg ac_sense_input_second,
  output reg power_on_request,
  input wire dc_good_status,
  // Monitor indications per pin
  output reg [3:0] flag,
  output reg [3:0] overvoltage_indication,
  output reg [3:0] undervoltage_indication,
  // Interrupt
  output wire irq
);

  // --------------------------------------------------------------------------
  // Registers and state
  // --------------------------------------------------------------------------
  reg [7:0] sel_a;
  reg [7:0] sel_b;
  reg [7:0] irq_stat;
  reg [7:0] irq_mask;
  reg [3:0] hi_meta;
  reg [3:0] hi_sync;
  reg [3:0] lo_meta;
  reg [3:0] lo_sync;
  reg [2:0] pin_meta;
  reg [2:0] pin_sync;
  reg [3:0] hyst;
  reg [3:0] next_hyst;
  reg [3:0] prev_ov;
  reg [3:0] prev_uv;
  reg [3:0] next_flag;
  reg [3:0] next_ov;
  reg [3:0] next_uv;
  reg [3:0] next_window;
  reg [11:0] code_all;
  reg [2:0] code;
  reg [7:0] next_irq_stat;
  reg [7:0] events;
  reg [31:0] next_rdata;
  reg next_err;
  reg mapped;
  integer i;

  wire [2:0] pin1_sel;
  wire [2:0] pin2_sel;
  wire [2:0] pin3_sel;
  wire [2:0] pin4_sel;
  wire dc_good_polarity_bit;
  wire setup;
  wire access;
  wire wr;
  wire rd_stat;

  assign pin1_sel = sel_a[`MPS_PIN1_SEL_HI:`MPS_PIN1_SEL_LO];
  assign pin2_sel = sel_a[`MPS_PIN2_SEL_HI:`MPS_PIN2_SEL_LO];
  assign pin3_sel = sel_b[`MPS_PIN3_SEL_HI:`MPS_PIN3_SEL_LO];
  assign pin4_sel = sel_b[`MPS_PIN4_SEL_HI:`MPS_PIN4_SEL_LO];
  assign dc_good_polarity_bit = sel_b[`MPS_DCG_POL_BIT];

  // --------------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_meta <= 4'h0;
      hi_sync <= 4'h0;
      lo_meta <= 4'h0;
      lo_sync <= 4'h0;
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      hi_meta <= cmp_above_upper;
      hi_sync <= hi_meta;
      lo_meta <= cmp_below_lower;
      lo_sync <= lo_meta;
      pin_meta <= {multipurpose_pin_3, multipurpose_pin_2, multipurpose_pin_1};
      pin_sync <= pin_meta;
    end
  end

  // --------------------------------------------------------------------------
  // Hysteresis and mode mapping
  // --------------------------------------------------------------------------
  always @* begin
    code_all = {pin4_sel, pin3_sel, pin2_sel, pin1_sel};
    code = 3'h0;
    next_hyst = hyst;
    next_flag = 4'h0;
    next_ov = 4'h0;
    next_uv = 4'h0;
    next_window = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      code = code_all[3*i +: 3];
      if (hi_sync[i])
        next_hyst[i] = 1'b1;
      else if (lo_sync[i])
        next_hyst[i] = 1'b0;
      case (code)
        `MPS_CODE_POS_OV: begin
          next_flag[i] = hyst[i];
          next_ov[i] = hyst[i];
        end
        `MPS_CODE_POS_UV: begin
          next_window[i] = 1'b1;
          next_flag[i] = hyst[i];
          next_uv[i] = ~hyst[i];
        end
        `MPS_CODE_NEG_OV: begin
          next_window[i] = 1'b1;
          next_flag[i] = hyst[i];
          next_ov[i] = ~hyst[i];
        end
        `MPS_CODE_NEG_UV: begin
          next_flag[i] = hyst[i];
          next_uv[i] = hyst[i];
        end
        `MPS_CODE_FLAG: begin
          next_flag[i] = hyst[i];
        end
        `MPS_CODE_FLAG_INV: begin
          next_flag[i] = ~hyst[i];
        end
        default: begin
          next_flag[i] = 1'b0;
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hyst <= 4'h0;
      flag <= 4'h0;
      overvoltage_indication <= 4'h0;
      undervoltage_indication <= 4'h0;
      thr_window_high <= 4'h0;
      prev_ov <= 4'h0;
      prev_uv <= 4'h0;
    end else begin
      hyst <= next_hyst;
      flag <= next_flag;
      overvoltage_indication <= next_ov;
      undervoltage_indication <= next_uv;
      thr_window_high <= next_window;
      prev_ov <= overvoltage_indication;
      prev_uv <= undervoltage_indication;
    end
  end

  // --------------------------------------------------------------------------
  // Dedicated functions
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ac_sense_input_first <= 1'b0;
      ac_sense_input_second <= 1'b0;
      power_on_request <= 1'b0;
      multipurpose_pin_4_out <= 1'b0;
      multipurpose_pin_4_oe <= 1'b0;
    end else begin
      ac_sense_input_first <= (pin1_sel[2:1] == 2'h0) & pin_sync[0];
      ac_sense_input_second <= (pin2_sel[2:1] == 2'h0) & pin_sync[1];
      if (pin3_sel == `MPS_CODE_DED0)
        power_on_request <= ~pin_sync[2];
      else if (pin3_sel == `MPS_CODE_DED1)
        power_on_request <= pin_sync[2];
      else
        power_on_request <= 1'b0;
      multipurpose_pin_4_oe <= (pin4_sel[2:1] == 2'h0);
      multipurpose_pin_4_out <= (pin4_sel[2:1] == 2'h0) &
        ~(dc_good_status ^ dc_good_polarity_bit);
    end
  end

  // --------------------------------------------------------------------------
  // APB slave and interrupt
  // --------------------------------------------------------------------------
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign pready = 1'b1;
  assign wr = access & pwrite;
  assign rd_stat = access & ~pwrite & (paddr == `MPS_ADDR_IRQ_STAT);
  assign irq = |(irq_stat & irq_mask);

  always @* begin
    events = {undervoltage_indication & ~prev_uv, overvoltage_indication & ~prev_ov};
    // Clears only the bits returned, so an event at the setup edge survives
    next_irq_stat = (rd_stat ? (irq_stat & ~prdata[7:0]) : irq_stat) | events;
    mapped = 1'b1;
    next_rdata = 32'h0000_0000;
    case (paddr)
      `MPS_ADDR_SEL_A: next_rdata[7:0] = sel_a;
      `MPS_ADDR_SEL_B: next_rdata[7:0] = sel_b;
      `MPS_ADDR_STATUS: next_rdata[15:0] = {power_on_request, ac_sense_input_second,
        ac_sense_input_first, hyst[0], undervoltage_indication,
        overvoltage_indication, flag};
      `MPS_ADDR_IRQ_STAT: next_rdata[7:0] = irq_stat;
      `MPS_ADDR_IRQ_MASK: next_rdata[7:0] = irq_mask;
      default: mapped = 1'b0;
    endcase
    next_err = ~mapped;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_a <= `MPS_SEL_A_RST;
      sel_b <= `MPS_SEL_B_RST;
      irq_mask <= `MPS_MASK_RST;
      irq_stat <= 8'h00;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        pslverr <= next_err;
      end
      if (wr && paddr == `MPS_ADDR_SEL_A)
        sel_a <= pwdata[7:0];
      if (wr && paddr == `MPS_ADDR_SEL_B)
        sel_b <= pwdata[7:0];
      if (wr && paddr == `MPS_ADDR_IRQ_MASK)
        irq_mask <= pwdata[7:0];
    end
  end

endmodule // mps_pin_select
`default_nettype wire

// *** shared/mps_map.vh ***
// Purpose: Register map, field positions and codes of the monitor pin select
// Assumes: 32-bit APB, byte addresses
// Notes: Included by logic/mps_pin_select.v
`ifndef MPS_MAP_VH
`define MPS_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define MPS_ADDR_SEL_A 8'h00
`define MPS_ADDR_SEL_B 8'h04
`define MPS_ADDR_STATUS 8'h08
`define MPS_ADDR_IRQ_STAT 8'h0c
`define MPS_ADDR_IRQ_MASK 8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MPS_PIN1_SEL_HI 3
`define MPS_PIN1_SEL_LO 1
`define MPS_PIN2_SEL_HI 7
`define MPS_PIN2_SEL_LO 5
`define MPS_PIN3_SEL_HI 4
`define MPS_PIN3_SEL_LO 2
`define MPS_PIN4_SEL_HI 7
`define MPS_PIN4_SEL_LO 5
`define MPS_DCG_POL_BIT 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MPS_SEL_A_RST 8'h00
`define MPS_SEL_B_RST 8'h00
`define MPS_MASK_RST 8'h00

// ----------------------------------------------------------------------------
// Select codes
// ----------------------------------------------------------------------------
`define MPS_CODE_DED0 3'h0
`define MPS_CODE_DED1 3'h1
`define MPS_CODE_POS_OV 3'h2
`define MPS_CODE_POS_UV 3'h3
`define MPS_CODE_NEG_OV 3'h4
`define MPS_CODE_NEG_UV 3'h5
`define MPS_CODE_FLAG 3'h6
`define MPS_CODE_FLAG_INV 3'h7

`endif

// *** tb/mps_sense_model.sv ***
// Purpose: Supply sense points behind the four monitor pins
// Assumes: All pins share one level in millivolts
// Notes: Window choice comes back from the block
`default_nettype none
module mps_sense_model (
  // Window per pin and level
  input wire logic [3:0] thr_window_high,
  input wire logic [15:0] level_mv,
  // Comparator levels
  output logic [3:0] cmp_above_upper,
  output logic [3:0] cmp_below_lower
);
  timeunit 1ns;
  timeprecision 1ps;
  // Thresholds 1.35/1.25 V or 1.25/1.15 V
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cmp_above_upper[i] = level_mv > (thr_window_high[i] ? 16'h0546 : 16'h04e2);
      cmp_below_lower[i] = level_mv < (thr_window_high[i] ? 16'h04e2 : 16'h047e);
    end
  end
endmodule // mps_sense_model
`default_nettype wire

// *** tb/mps_pin_select_checker.sv ***
// Purpose: Port assertions for the monitor pin select
// Assumes: Select decode and monitor outputs share one register stage
// Notes: Bound from the bench top file
`include "mps_map.vh"
`default_nettype none
module mps_pin_select_checker (
  // Clock, reset, bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  // Pin side
  input wire logic [3:0] thr_window_high,
  input wire logic ac_sense_input_first,
  input wire logic ac_sense_input_second,
  input wire logic power_on_request,
  input wire logic multipurpose_pin_4_oe,
  input wire logic [3:0] flag,
  input wire logic [3:0] overvoltage_indication,
  input wire logic [3:0] undervoltage_indication
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wr_b;
  wire [3:0] ovuv = overvoltage_indication | undervoltage_indication;
  wire [3:0] busy = ovuv | flag;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Starts at ones so the first decode after reset is allowed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_b <= 2'h3;
    else wr_b <= {wr_b[0], psel && penable && pwrite && paddr == `MPS_ADDR_SEL_B};
  end
  ovuv_excl_a: assert property ((overvoltage_indication & undervoltage_indication) == 4'h0)
    else $error("ov and uv both high");
  high_window_a: assert property (
    ((flag ^ ovuv) | ~(thr_window_high & $past(thr_window_high))) == 4'hf)
    else $error("high window flag clash");
  low_window_a: assert property (
    (ovuv & ~flag & ~(thr_window_high | $past(thr_window_high))) == 4'h0)
    else $error("low window flag clash");
  ac_first_a: assert property (ac_sense_input_first |-> !busy[0])
    else $error("pin 1 monitor active");
  ac_second_a: assert property (ac_sense_input_second |-> !busy[1])
    else $error("pin 2 monitor active");
  pon_quiet_a: assert property (power_on_request |-> !busy[2])
    else $error("pin 3 monitor active");
  pin4_quiet_a: assert property (multipurpose_pin_4_oe |-> !busy[3])
    else $error("pin 4 monitor active");
  oe_cause_a: assert property ($changed(multipurpose_pin_4_oe) |-> wr_b != 2'h0)
    else $error("pin 4 drive changed unasked");
endmodule // mps_pin_select_checker
`default_nettype wire

// *** tb/multipurpose_monitor_pin_select_tb.sv ***
// Purpose: Self-checking bench for the monitor pin select
// Assumes: Outputs settle within eight cycles of a change
// Notes: All four pins share one select code and one level
`include "mps_map.vh"
`default_nettype none
module multipurpose_monitor_pin_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [2:0] code; logic [15:0] mv; logic [2:0] fou;} mps_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic multipurpose_pin_1 = 1'b1;
  logic multipurpose_pin_2 = 1'b0;
  logic multipurpose_pin_3 = 1'b0;
  logic dc_good_status = 1'b1;
  logic [15:0] level_mv = 16'h044c;
  logic [31:0] prdata, rd, exp;
  logic pready, pslverr, err, irq, multipurpose_pin_4_out, multipurpose_pin_4_oe;
  logic ac_sense_input_first, ac_sense_input_second, power_on_request;
  logic [3:0] cmp_above_upper, cmp_below_lower, thr_window_high;
  logic [3:0] flag, overvoltage_indication, undervoltage_indication;
  logic [7:0] regs [3] = '{`MPS_ADDR_SEL_A, `MPS_ADDR_SEL_B, `MPS_ADDR_IRQ_MASK};
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  // Code, level, expected flag/ov/uv; third row holds inside the hysteresis
  mps_row_t rows [13] = '{'{3'h2, 16'h044c, 3'h0}, '{3'h2, 16'h0514, 3'h6},
    '{3'h2, 16'h04b0, 3'h6}, '{3'h3, 16'h04b0, 3'h1}, '{3'h3, 16'h0578, 3'h4},
    '{3'h4, 16'h04b0, 3'h2}, '{3'h4, 16'h0578, 3'h4}, '{3'h5, 16'h044c, 3'h0},
    '{3'h5, 16'h0514, 3'h5}, '{3'h6, 16'h044c, 3'h0}, '{3'h6, 16'h0514, 3'h4},
    '{3'h7, 16'h0514, 3'h0}, '{3'h7, 16'h044c, 3'h4}};
  mps_pin_select DUT (.*);
  mps_sense_model partner (.*);
  always #2 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set_code(input logic [2:0] c, input logic pol);
    apb(1'b1, `MPS_ADDR_SEL_A, {24'h0, c, 1'b0, c, 1'b0});
    apb(1'b1, `MPS_ADDR_SEL_B, {24'h0, c, c, 1'b0, pol});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    repeat (12) @(posedge pclk);
    chk({18'h0, irq, multipurpose_pin_4_oe, flag, overvoltage_indication,
      undervoltage_indication}, 32'h0);
    presetn <= 1'b1;
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 32'h0);
      chk(rd, 32'h0);
    end
    $display("reset test done");
    foreach (rows[i]) begin
      set_code(rows[i].code, 1'b1);
      level_mv <= rows[i].mv;
      repeat (8) @(posedge pclk);
      exp = {20'h0, {4{rows[i].fou[2]}}, {4{rows[i].fou[1]}}, {4{rows[i].fou[0]}}};
      chk({20'h0, flag, overvoltage_indication, undervoltage_indication}, exp);
    end
    $display("monitor test done");
    // Bit 0 picks code and polarity, bit 1 the pin and DC good levels
    for (int c = 0; c < 4; c++) begin
      multipurpose_pin_1 <= c[1];
      multipurpose_pin_2 <= ~c[1];
      multipurpose_pin_3 <= c[1];
      dc_good_status <= c[1];
      set_code({2'h0, c[0]}, c[0]);
      repeat (8) @(posedge pclk);
      exp = {23'h0, c[1], ~c[1], ~(c[0] ^ c[1]), 1'b1, ~(c[0] ^ c[1]), 4'h0};
      rd = {23'h0, ac_sense_input_first, ac_sense_input_second, power_on_request, 6'h0};
      chk(rd | {26'h0, multipurpose_pin_4_oe, multipurpose_pin_4_out, flag}, exp);
    end
    $display("dedicated test done");
    set_code(3'h2, 1'b1);
    repeat (8) @(posedge pclk);
    apb(1'b0, `MPS_ADDR_IRQ_STAT, 32'h0);
    level_mv <= 16'h0514;
    repeat (8) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `MPS_ADDR_IRQ_MASK, 32'hff);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `MPS_ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h0f);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({rd[31:1], err}, 32'h1);
    $display("interrupt test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({18'h0, irq, multipurpose_pin_4_oe, flag, overvoltage_indication,
      undervoltage_indication}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, `MPS_ADDR_SEL_B, 32'h0);
    chk(rd, 32'h0);
    $display("reset again test done");
    test_done();
  end
endmodule // multipurpose_monitor_pin_select_tb
bind mps_pin_select mps_pin_select_checker chk (.*);
`default_nettype wire
